// ==== core/ucr_regs.svh ====
`ifndef UCR_REGS_SVH
`define UCR_REGS_SVH
// request types
`define UCR_RT_DEV_OUT 8'h00
`define UCR_RT_IF_OUT 8'h01
`define UCR_RT_EP_OUT 8'h02
`define UCR_RT_DEV_IN 8'h80
`define UCR_RT_IF_IN 8'h81
`define UCR_RT_EP_IN 8'h82
`define UCR_RT_VND_OUT 8'h40
`define UCR_RT_VND_IN 8'hc0
// request codes
`define UCR_RQ_GET_STATUS 8'h00
`define UCR_RQ_CLR_FEAT 8'h01
`define UCR_RQ_SET_FEAT 8'h03
`define UCR_RQ_SET_ADDR 8'h05
`define UCR_RQ_GET_DESC 8'h06
`define UCR_RQ_GET_CFG 8'h08
`define UCR_RQ_SET_CFG 8'h09
`define UCR_RQ_GET_IF 8'h0a
`define UCR_RQ_SET_IF 8'h0b
`define UCR_RQ_REG_WR 8'ha0
`define UCR_RQ_REG_RD 8'ha1
`define UCR_RQ_STATS 8'ha2
// descriptor types in wValue high byte
`define UCR_DT_DEVICE 8'h01
`define UCR_DT_CONFIG 8'h02
`define UCR_DT_STRING 8'h03
`define UCR_DT_QUAL 8'h06
`define UCR_DT_OTHER 8'h07
// feature selectors
`define UCR_FS_HALT 16'h0000
`define UCR_FS_WAKE 16'h0001
`define UCR_FS_TEST 16'h0002
// endpoint addresses in wIndex
`define UCR_EP_BULK_IN 16'h0081
`define UCR_EP_BULK_OUT 16'h0002
`define UCR_EP_INTR 16'h0083
// lengths, configuration value and highest address
`define UCR_LEN_ONE 16'h0001
`define UCR_LEN_TWO 16'h0002
`define UCR_LEN_REG 16'h0004
`define UCR_LEN_RX 16'h0028
`define UCR_LEN_TX 16'h0030
`define UCR_CFG_VALUE 16'h0001
`define UCR_ADDR_MAX 16'h007f
// avalon register word indices
`define UCR_REG_CTRL 2'h0
`define UCR_REG_MACWIN 2'h1
`define UCR_REG_STATUS 2'h2
// control bit positions
`define UCR_CTRL_SELFPWR 0
`define UCR_CTRL_NORMAL 1
// reset values
`define UCR_CTRL_RST 32'h0000_0000
`define UCR_MACWIN_RST 32'h01ff_0100
`endif

// ==== core/ucr_pkg.sv ====
package ucr_pkg;
   typedef enum logic [3:0] {
      UCR_ST_IDLE = 4'b0001,
      UCR_ST_WR = 4'b0010,
      UCR_ST_RDW = 4'b0100,
      UCR_ST_SEND = 4'b1000
   } ucr_fsm_t;

   typedef struct packed {
      ucr_fsm_t st;
      logic [6:0] addr;
      logic cfg;
      logic rwake;
      logic tmode;
      logic [7:0] tsel;
      logic [2:0] halt;
      logic [5:0] cnt;
      logic [5:0] len;
      logic [11:0] csra;
      logic [11:0][31:0] sbuf;
      logic in_valid;
      logic [7:0] in_byte;
      logic in_last;
      logic ack;
      logic stall;
      logic csr_wr;
      logic csr_rd;
      logic [31:0] wdata;
      logic desc_start;
      logic [7:0] desc_type;
      logic [7:0] desc_idx;
      logic [15:0] desc_lang;
      logic [15:0] desc_len;
   } ucr_state_t;

   typedef struct packed {
      logic wait_n;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [31:0] macwin;
   } ucr_avs_state_t;
endpackage : ucr_pkg

// ==== core/ucr_avs.sv ====
`include "ucr_regs.svh"
module ucr_avs
   import ucr_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // avalon slave
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // block state
   input wire logic [31:0] status_word,
   output logic self_powered,
   output logic normal_state,
   output logic [11:0] mac_lo,
   output logic [11:0] mac_hi
);
   ucr_avs_state_t q, n;
   logic req;

   assign req = avs_read | avs_write;

   always_comb begin
      n = q;
      // waitrequest drops for exactly one cycle per request
      n.wait_n = req & ~q.wait_n;
      if (req & ~q.wait_n) begin
         unique case (avs_address)
            `UCR_REG_CTRL: n.rdata = q.ctrl;
            `UCR_REG_MACWIN: n.rdata = q.macwin;
            `UCR_REG_STATUS: n.rdata = status_word;
            default: n.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write & q.wait_n) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
               if (avs_address == `UCR_REG_CTRL)
                  n.ctrl[b*8 +: 8] = avs_writedata[b*8 +: 8];
               if (avs_address == `UCR_REG_MACWIN)
                  n.macwin[b*8 +: 8] = avs_writedata[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '{wait_n: 1'b0, rdata: 32'h0000_0000, ctrl: `UCR_CTRL_RST,
                macwin: `UCR_MACWIN_RST};
      end else begin
         q <= n;
      end
   end

   assign avs_readdata = q.rdata;
   assign avs_waitrequest = ~q.wait_n;
   assign self_powered = q.ctrl[`UCR_CTRL_SELFPWR];
   assign normal_state = q.ctrl[`UCR_CTRL_NORMAL];
   assign mac_lo = q.macwin[11:0];
   assign mac_hi = q.macwin[27:16];
endmodule : ucr_avs

// ==== core/ucr_decoder.sv ====
`include "ucr_regs.svh"
module ucr_decoder
   import ucr_pkg::*;
#(
   parameter int RX_WORDS = 8,
   parameter int TX_WORDS = 10
)(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // setup packet
   input wire logic setup_valid,
   input wire logic [7:0] setup_type,
   input wire logic [7:0] setup_req,
   input wire logic [15:0] setup_value,
   input wire logic [15:0] setup_index,
   input wire logic [15:0] setup_length,
   // out data stage
   input wire logic out_valid,
   input wire logic [7:0] out_byte,
   // in data stage
   output logic in_valid,
   output logic [7:0] in_byte,
   output logic in_last,
   input wire logic in_ready,
   // handshake
   output logic hs_ack,
   output logic hs_stall,
   // descriptor source
   output logic desc_start,
   output logic [7:0] desc_type,
   output logic [7:0] desc_idx,
   output logic [15:0] desc_lang,
   output logic [15:0] desc_len,
   // register access port
   output logic csr_wr,
   output logic csr_rd,
   output logic [11:0] csr_addr,
   output logic [31:0] csr_wdata,
   input wire logic [31:0] csr_rdata,
   // statistics counters
   input wire logic [RX_WORDS*32-1:0] rx_stats,
   input wire logic [TX_WORDS*32-1:0] tx_stats,
   // device state
   output logic [6:0] dev_addr,
   output logic configured,
   output logic remote_wake_en,
   output logic test_mode,
   output logic [7:0] test_sel,
   output logic [2:0] ep_halt,
   // avalon slave
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   ucr_state_t q, n;
   logic self_powered;
   logic normal_state;
   logic [11:0] mac_lo;
   logic [11:0] mac_hi;
   logic [31:0] status_word;
   logic [11:0][31:0] rx_word;
   logic [11:0][31:0] tx_word;
   logic [2:0] ep_sel;
   logic mac_hit;
   logic vnd_ok;

   ucr_avs u_avs (
      .core_clk(core_clk),
      .rst(rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .status_word(status_word),
      .self_powered(self_powered),
      .normal_state(normal_state),
      .mac_lo(mac_lo),
      .mac_hi(mac_hi)
   );

   assign status_word = {11'h000, q.tmode, q.tsel, q.halt, q.rwake, q.cfg, q.addr};

   // reserved words of the statistics image read as zero
   for (genvar k = 0; k < 12; k++) begin : g_stat
      if (k < RX_WORDS) begin : g_rx
         assign rx_word[k] = rx_stats[k*32 +: 32];
      end else begin : g_rx0
         assign rx_word[k] = 32'h0000_0000;
      end
      if (k < TX_WORDS) begin : g_tx
         assign tx_word[k] = tx_stats[k*32 +: 32];
      end else begin : g_tx0
         assign tx_word[k] = 32'h0000_0000;
      end
   end

   always_comb begin
      unique case (setup_index)
         `UCR_EP_BULK_IN: ep_sel = 3'h1;
         `UCR_EP_BULK_OUT: ep_sel = 3'h2;
         `UCR_EP_INTR: ep_sel = 3'h4;
         default: ep_sel = 3'h0;
      endcase
   end

   assign mac_hit = normal_state && setup_index[11:0] >= mac_lo
                    && setup_index[11:0] <= mac_hi;
   assign vnd_ok = setup_value == 16'h0000 && setup_index[15:12] == 4'h0
                   && setup_length == `UCR_LEN_REG;

   always_comb begin
      n = q;
      n.ack = 1'b0;
      n.stall = 1'b0;
      n.csr_wr = 1'b0;
      n.csr_rd = 1'b0;
      n.desc_start = 1'b0;
      unique case (q.st)
         UCR_ST_IDLE: begin
         end
         UCR_ST_WR: begin
            if (out_valid) begin
               n.wdata[{q.cnt[1:0], 3'b000} +: 8] = out_byte;
               n.cnt = q.cnt + 6'h01;
               if (q.cnt[1:0] == 2'h3) begin
                  n.csr_wr = 1'b1;
                  n.ack = 1'b1;
                  n.st = UCR_ST_IDLE;
               end
            end
         end
         UCR_ST_RDW: begin
            // read data is valid the cycle after the strobe
            if (!q.csr_rd) begin
               n.sbuf[0] = csr_rdata;
               n.st = UCR_ST_SEND;
            end
         end
         UCR_ST_SEND: begin
            if (!q.in_valid || in_ready) begin
               if (q.cnt < q.len) begin
                  n.in_valid = 1'b1;
                  n.in_byte = q.sbuf[q.cnt[5:2]][{q.cnt[1:0], 3'b000} +: 8];
                  n.in_last = q.cnt == q.len - 6'h01;
                  n.cnt = q.cnt + 6'h01;
               end else begin
                  n.in_valid = 1'b0;
                  n.in_last = 1'b0;
                  n.ack = 1'b1;
                  n.st = UCR_ST_IDLE;
               end
            end
         end
      endcase

      // a new setup packet aborts whatever is in flight except a csr_wr or ack already due in the same cycle
      if (setup_valid) begin
         n.st = UCR_ST_IDLE;
         n.cnt = 6'h00;
         n.in_valid = 1'b0;
         n.in_last = 1'b0;
         n.stall = 1'b1;
         unique case ({setup_type, setup_req})
            {`UCR_RT_DEV_IN, `UCR_RQ_GET_CFG}: begin
               if (setup_value == 16'h0000 && setup_index == 16'h0000
                   && setup_length == `UCR_LEN_ONE) begin
                  n.stall = 1'b0;
                  n.sbuf[0] = {31'h0000_0000, q.cfg};
                  n.len = 6'h01;
                  n.st = UCR_ST_SEND;
               end
            end
            {`UCR_RT_DEV_IN, `UCR_RQ_GET_DESC}: begin
               if (setup_value[15:8] == `UCR_DT_DEVICE || setup_value[15:8] == `UCR_DT_CONFIG
                   || setup_value[15:8] == `UCR_DT_STRING || setup_value[15:8] == `UCR_DT_QUAL
                   || setup_value[15:8] == `UCR_DT_OTHER) begin
                  n.stall = 1'b0;
                  n.ack = 1'b1;
                  n.desc_start = 1'b1;
                  n.desc_type = setup_value[15:8];
                  n.desc_idx = setup_value[7:0];
                  n.desc_lang = setup_index;
                  n.desc_len = setup_length;
               end
            end
            {`UCR_RT_IF_IN, `UCR_RQ_GET_IF}: begin
               if (setup_value == 16'h0000 && setup_index == 16'h0000
                   && setup_length == `UCR_LEN_ONE) begin
                  n.stall = 1'b0;
                  n.sbuf[0] = 32'h0000_0000;
                  n.len = 6'h01;
                  n.st = UCR_ST_SEND;
               end
            end
            {`UCR_RT_DEV_IN, `UCR_RQ_GET_STATUS}: begin
               if (setup_value == 16'h0000 && setup_index == 16'h0000
                   && setup_length == `UCR_LEN_TWO) begin
                  n.stall = 1'b0;
                  n.sbuf[0] = {30'h0000_0000, q.rwake, self_powered};
                  n.len = 6'h02;
                  n.st = UCR_ST_SEND;
               end
            end
            {`UCR_RT_EP_IN, `UCR_RQ_GET_STATUS}: begin
               if (setup_value == 16'h0000 && ep_sel != 3'h0
                   && setup_length == `UCR_LEN_TWO) begin
                  n.stall = 1'b0;
                  n.sbuf[0] = {31'h0000_0000, |(q.halt & ep_sel)};
                  n.len = 6'h02;
                  n.st = UCR_ST_SEND;
               end
            end
            {`UCR_RT_DEV_OUT, `UCR_RQ_SET_ADDR}: begin
               if (setup_value <= `UCR_ADDR_MAX && setup_index == 16'h0000
                   && setup_length == 16'h0000) begin
                  n.stall = 1'b0;
                  n.ack = 1'b1;
                  n.addr = setup_value[6:0];
               end
            end
            {`UCR_RT_DEV_OUT, `UCR_RQ_SET_FEAT}, {`UCR_RT_DEV_OUT, `UCR_RQ_CLR_FEAT}: begin
               if (setup_length == 16'h0000 && setup_index[7:0] == 8'h00) begin
                  if (setup_value == `UCR_FS_WAKE) begin
                     n.stall = 1'b0;
                     n.ack = 1'b1;
                     n.rwake = setup_req == `UCR_RQ_SET_FEAT;
                  end else if (setup_value == `UCR_FS_TEST && setup_req == `UCR_RQ_SET_FEAT
                               && setup_index[15:8] != 8'h00) begin
                     n.stall = 1'b0;
                     n.ack = 1'b1;
                     n.tmode = 1'b1;
                     n.tsel = setup_index[15:8];
                  end
               end
            end
            {`UCR_RT_EP_OUT, `UCR_RQ_SET_FEAT}, {`UCR_RT_EP_OUT, `UCR_RQ_CLR_FEAT}: begin
               if (setup_value == `UCR_FS_HALT && ep_sel != 3'h0
                   && setup_length == 16'h0000) begin
                  n.stall = 1'b0;
                  n.ack = 1'b1;
                  if (setup_req == `UCR_RQ_SET_FEAT)
                     n.halt = q.halt | ep_sel;
                  else
                     n.halt = q.halt & ~ep_sel;
               end
            end
            {`UCR_RT_DEV_OUT, `UCR_RQ_SET_CFG}: begin
               if (setup_value == `UCR_CFG_VALUE && setup_index == 16'h0000
                   && setup_length == 16'h0000) begin
                  n.stall = 1'b0;
                  n.ack = 1'b1;
                  n.cfg = 1'b1;
               end
            end
            {`UCR_RT_IF_OUT, `UCR_RQ_SET_IF}: begin
               if (setup_value == 16'h0000 && setup_index == 16'h0000
                   && setup_length == 16'h0000) begin
                  n.stall = 1'b0;
                  n.ack = 1'b1;
               end
            end
            {`UCR_RT_VND_OUT, `UCR_RQ_REG_WR}: begin
               if (vnd_ok && !mac_hit) begin
                  n.stall = 1'b0;
                  n.csra = setup_index[11:0];
                  n.st = UCR_ST_WR;
               end
            end
            {`UCR_RT_VND_IN, `UCR_RQ_REG_RD}: begin
               if (vnd_ok && !mac_hit) begin
                  n.stall = 1'b0;
                  n.csra = setup_index[11:0];
                  n.csr_rd = 1'b1;
                  n.sbuf = '0;
                  n.len = 6'h04;
                  n.st = UCR_ST_RDW;
               end
            end
            {`UCR_RT_VND_IN, `UCR_RQ_STATS}: begin
               // wIndex bit 0 picks the transmit set
               if (setup_value == 16'h0000 && setup_index[15:1] == 15'h0000
                   && setup_length == (setup_index[0] ? `UCR_LEN_TX : `UCR_LEN_RX)) begin
                  n.stall = 1'b0;
                  n.sbuf = setup_index[0] ? tx_word : rx_word;
                  n.len = setup_length[5:0];
                  n.st = UCR_ST_SEND;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.st <= UCR_ST_IDLE;
      end else begin
         q <= n;
      end
   end

   assign in_valid = q.in_valid;
   assign in_byte = q.in_byte;
   assign in_last = q.in_last;
   assign hs_ack = q.ack;
   assign hs_stall = q.stall;
   assign desc_start = q.desc_start;
   assign desc_type = q.desc_type;
   assign desc_idx = q.desc_idx;
   assign desc_lang = q.desc_lang;
   assign desc_len = q.desc_len;
   assign csr_wr = q.csr_wr;
   assign csr_rd = q.csr_rd;
   assign csr_addr = q.csra;
   assign csr_wdata = q.wdata;
   assign dev_addr = q.addr;
   assign configured = q.cfg;
   assign remote_wake_en = q.rwake;
   assign test_mode = q.tmode;
   assign test_sel = q.tsel;
   assign ep_halt = q.halt;

   // checks
   a_cfg_len: assert property (@(posedge core_clk) disable iff (rst)
      setup_valid && setup_type == `UCR_RT_DEV_IN && setup_req == `UCR_RQ_GET_CFG
      && setup_value == 16'h0000 && setup_index == 16'h0000 && setup_length == `UCR_LEN_ONE
      |=> q.st == UCR_ST_SEND && q.len == 6'h01 && q.sbuf[0][0] == $past(q.cfg))
      else $error("get configuration not loaded");
   a_desc_iface_stall: assert property (@(posedge core_clk) disable iff (rst)
      setup_valid && setup_type == `UCR_RT_DEV_IN && setup_req == `UCR_RQ_GET_DESC
      && (setup_value[15:8] == 8'h04 || setup_value[15:8] == 8'h05)
      |=> hs_stall && !desc_start)
      else $error("interface or endpoint descriptor not stalled");
   a_addr_adopt: assert property (@(posedge core_clk) disable iff (rst)
      setup_valid && setup_type == `UCR_RT_DEV_OUT && setup_req == `UCR_RQ_SET_ADDR
      && setup_value <= `UCR_ADDR_MAX && setup_index == 16'h0000 && setup_length == 16'h0000
      |=> dev_addr == $past(setup_value[6:0]) && hs_ack)
      else $error("address not adopted");
   a_cfg_one_only: assert property (@(posedge core_clk) disable iff (rst)
      setup_valid && setup_type == `UCR_RT_DEV_OUT && setup_req == `UCR_RQ_SET_CFG
      && setup_value != `UCR_CFG_VALUE |=> hs_stall && configured == $past(configured))
      else $error("bad configuration value accepted");
   a_mac_stall: assert property (@(posedge core_clk) disable iff (rst)
      setup_valid && setup_type[6] && mac_hit
      && (setup_req == `UCR_RQ_REG_WR || setup_req == `UCR_RQ_REG_RD) |=> hs_stall && !csr_rd)
      else $error("mac register access not stalled");
   a_write_once: assert property (@(posedge core_clk) disable iff (rst)
      csr_wr |-> hs_ack && $past(q.st == UCR_ST_WR && out_valid) ##1 !csr_wr)
      else $error("register write not single");
   a_read_four: assert property (@(posedge core_clk) disable iff (rst)
      csr_rd && !setup_valid |=> q.st == UCR_ST_RDW ##1 q.len == 6'h04
      && (setup_valid || q.sbuf[0] == $past(csr_rdata)))
      else $error("register read not returned");
   a_stats_snap: assert property (@(posedge core_clk) disable iff (rst)
      setup_valid && setup_type == `UCR_RT_VND_IN && setup_req == `UCR_RQ_STATS
      && setup_value == 16'h0000 && setup_index == 16'h0000 && setup_length == `UCR_LEN_RX
      |=> q.len == 6'h28 && q.sbuf[0] == $past(rx_stats[31:0]) && q.sbuf[9] == 32'h0000_0000)
      else $error("statistics snapshot wrong");
   a_ack_xor_stall: assert property (@(posedge core_clk) disable iff (rst)
      !(hs_ack && hs_stall))
      else $error("ack and stall together");
   c_stats_tx: cover property (@(posedge core_clk) disable iff (rst)
      q.st == UCR_ST_SEND && q.len == 6'h30 ##[1:200] hs_ack);
   c_reg_write: cover property (@(posedge core_clk) disable iff (rst) csr_wr);
   c_reg_read: cover property (@(posedge core_clk) disable iff (rst)
      csr_rd ##[2:20] in_last);
   c_stall: cover property (@(posedge core_clk) disable iff (rst) hs_stall);
endmodule : ucr_decoder

// ==== tb/ucr_host.sv ====
module ucr_host (
   // clock
   input wire logic core_clk,
   // setup and out data stage
   output logic setup_valid,
   output logic [7:0] setup_type,
   output logic [7:0] setup_req,
   output logic [15:0] setup_value,
   output logic [15:0] setup_index,
   output logic [15:0] setup_length,
   output logic out_valid,
   output logic [7:0] out_byte,
   // in data stage and handshake
   input wire logic in_valid,
   input wire logic [7:0] in_byte,
   input wire logic hs_ack,
   input wire logic hs_stall,
   output logic in_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   logic [1:0] hs;
   initial begin
      {setup_valid, out_valid, in_ready, out_byte} = '0;
      {setup_type, setup_req, setup_value, setup_index, setup_length} = '0;
   end
   // slow consumer: ready only every other cycle
   always @(posedge core_clk) begin
      in_ready <= ~in_ready;
      if (in_valid && in_ready) got.push_back(in_byte);
      if (hs_ack || hs_stall) hs = {hs_stall, hs_ack};
   end
   task automatic run(input logic [7:0] t, r, input logic [15:0] v, i, l,
         input logic [31:0] d);
      @(posedge core_clk);
      got.delete();
      hs = 2'b00;
      setup_valid <= 1'b1;
      {setup_type, setup_req, setup_value, setup_index, setup_length} <= {t, r, v, i, l};
      @(posedge core_clk);
      setup_valid <= 1'b0;
      // released fields carry inverted junk, not the last request
      {setup_type, setup_req, setup_value, setup_index, setup_length} <= ~{t, r, v, i, l};
      if (t == 8'h40) for (int k = 0; k < 4; k++) begin
         out_valid <= 1'b1;
         out_byte <= d[8*k +: 8];
         @(posedge core_clk);
         out_valid <= 1'b0;
         out_byte <= ~d[8*k +: 8];
         @(posedge core_clk);
      end
      for (int k = 0; k < 300 && hs == 2'b00; k++) @(posedge core_clk);
      // let the edge that carried the handshake settle before results are read
      @(posedge core_clk);
   endtask : run
endmodule : ucr_host

// ==== tb/test_usb_control_request_decoder.sv ====
module test_usb_control_request_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] A = 2'b01, S = 2'b10;
   logic core_clk = 1'b0, rst = 1'b1;
   logic setup_valid, out_valid, in_valid, in_last, in_ready, hs_ack, hs_stall, desc_start;
   logic csr_wr, csr_rd, configured, remote_wake_en, test_mode, avs_waitrequest;
   logic [7:0] setup_type, setup_req, out_byte, in_byte, desc_type, desc_idx, test_sel;
   logic [15:0] setup_value, setup_index, setup_length, desc_lang, desc_len;
   logic [11:0] csr_addr;
   logic [31:0] csr_wdata, csr_rdata, avs_readdata, rd, w;
   logic [31:0] avs_writedata = '0;
   logic [255:0] rx_stats;
   logic [319:0] tx_stats;
   logic [6:0] dev_addr;
   logic [2:0] ep_halt;
   logic [1:0] avs_address = '0;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [43:0] last_wr = '0;
   logic [7:0] eps[3] = '{8'h81, 8'h02, 8'h83};
   logic [7:0] dts[7] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h04, 8'h05};
   int err_total = 0, n_checks = 0, cyc = 0, n;
   assign csr_rdata = {20'h5a5a5, csr_addr};
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (csr_wr) last_wr <= {csr_addr, csr_wdata};
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   ucr_host i_host (.core_clk, .setup_valid, .setup_type, .setup_req, .setup_value,
      .setup_index, .setup_length, .out_valid, .out_byte, .in_valid, .in_byte, .hs_ack,
      .hs_stall, .in_ready);
   ucr_decoder #(.RX_WORDS(8), .TX_WORDS(10)) i_dut (.core_clk, .rst, .setup_valid,
      .setup_type, .setup_req, .setup_value, .setup_index, .setup_length, .out_valid,
      .out_byte, .in_valid, .in_byte, .in_last, .in_ready, .hs_ack, .hs_stall, .desc_start,
      .desc_type, .desc_idx, .desc_lang, .desc_len, .csr_wr, .csr_rd, .csr_addr, .csr_wdata,
      .csr_rdata, .rx_stats, .tx_stats, .dev_addr, .configured, .remote_wake_en, .test_mode,
      .test_sel, .ep_halt, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest);
   task chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task results;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task av(input logic wr, input logic [1:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : av
   task rq(input logic [7:0] t, r, input logic [15:0] v, i, l, input logic [31:0] d,
         input logic [1:0] e);
      i_host.run(t, r, v, i, l, d);
      chk("handshake", {30'h0, e}, {30'h0, i_host.hs});
   endtask : rq
   function automatic logic [31:0] gw(input int k);
      return {i_host.got[k+3], i_host.got[k+2], i_host.got[k+1], i_host.got[k]};
   endfunction : gw
   // stats word k of bank s; words past the bank are reserved
   function automatic logic [31:0] sv(input int s, k);
      return {s ? 8'hb0 : 8'ha0, 8'(k), 16'hc3c3};
   endfunction : sv
   task fill;
      for (int k = 0; k < 10; k++) begin
         if (k < 8) rx_stats[32*k +: 32] <= sv(0, k);
         tx_stats[32*k +: 32] <= sv(1, k);
      end
   endtask : fill
   initial begin
      fill();
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rq(8'h80, 8'h08, 0, 0, 2, 0, S);
      rq(8'h80, 8'h08, 0, 0, 1, 0, A);
      chk("cfg byte", 0, i_host.got[0]);
      rq(8'h00, 8'h09, 2, 0, 0, 0, S);
      chk("configured", 0, configured);
      rq(8'h00, 8'h09, 1, 0, 0, 0, A);
      chk("configured", 1, configured);
      rq(8'h80, 8'h08, 0, 0, 1, 0, A);
      chk("cfg byte", 1, i_host.got[0]);
      rq(8'h81, 8'h0a, 0, 0, 1, 0, A);
      chk("alt setting", 0, i_host.got[0]);
      rq(8'h01, 8'h0b, 0, 0, 0, 0, A);
      rq(8'h01, 8'h0b, 1, 0, 0, 0, S);
      rq(8'h01, 8'h0b, 0, 1, 0, 0, S);
      rq(8'h00, 8'h05, 16'h002a, 0, 0, 0, A);
      chk("dev addr", 32'h2a, dev_addr);
      rq(8'h02, 8'h03, 0, 16'h0083, 0, 0, A);
      chk("halt", 3'b100, ep_halt);
      for (int k = 0; k < 3; k++) begin
         rq(8'h82, 8'h00, 0, eps[k], 2, 0, A);
         chk("ep status", k == 2, {i_host.got[1], i_host.got[0]});
      end
      av(1'b1, 2'h0, 32'h1);
      rq(8'h00, 8'h03, 1, 0, 0, 0, A);
      chk("wake en", 1, remote_wake_en);
      rq(8'h80, 8'h00, 0, 0, 2, 0, A);
      chk("dev status", 3, {i_host.got[1], i_host.got[0]});
      av(1'b0, 2'h2, 0);
      chk("status word", 32'h9aa, rd);
      av(1'b0, 2'h3, 0);
      chk("unmapped", 0, rd);
      for (int k = 0; k < 7; k++) begin
         rq(8'h80, 8'h06, {dts[k], 8'h00}, 0, 16'h12, 0, k < 5 ? A : S);
         if (k < 5) chk("desc type", dts[k], desc_type);
      end
      chk("desc len", 32'h12, desc_len);
      rq(8'h40, 8'ha0, 0, 16'h0123, 4, 32'hdeadbeef, A);
      chk("reg write", {12'h123, 32'hdeadbeef}, last_wr);
      rq(8'hc0, 8'ha1, 0, 16'h0456, 4, 0, A);
      chk("reg read", {20'h5a5a5, 12'h456}, gw(0));
      av(1'b1, 2'h0, 32'h3);
      rq(8'hc0, 8'ha1, 0, 16'h0150, 4, 0, S);
      rq(8'h40, 8'ha0, 0, 16'h01ff, 4, 32'h1, S);
      chk("write blocked", {12'h123, 32'hdeadbeef}, last_wr);
      av(1'b1, 2'h0, 32'h1);
      av(1'b0, 2'h0, 0);
      chk("ctrl", 1, rd);
      for (int s = 0; s < 2; s++) begin
         n = s ? 12 : 10;
         fork
            rq(8'hc0, 8'ha2, 0, 16'(s), 16'(4 * n), 0, A);
            begin
               repeat (3) @(posedge core_clk);
               {rx_stats, tx_stats} <= ~{rx_stats, tx_stats};
            end
         join
         fill();
         chk("stats len", 4 * n, i_host.got.size());
         for (int k = 0; k < n; k++) chk("stats word", k < n - 2 ? sv(s, k) : 0, gw(4 * k));
      end
      rq(8'h00, 8'h03, 2, 16'h0400, 0, 0, A);
      chk("test mode", 9'h104, {test_mode, test_sel});
      results();
   end
endmodule : test_usb_control_request_decoder
